// *** temp_sense_test_regs_reset_test.sv ***
/*
 Self-checking bench for tsr_top with a register model in integers.
 Assumes tsr_host drives the register port at the falling edge.
*/
`timescale 1ns/10ps
module temp_sense_test_regs_reset_test
  import tsr_pkg::*;
;
  logic clk, rst_n, en, hs, mm, rvalid, busy;
  logic [7:0] sample, rdata, d, v;
  logic signed [17:0] fo;
  tsr_req_s req;
  tsr_tune_s tune;
  int err_total, n_checks, k, c, ex;
  int m[int];
  logic [6:0] rw[5] = '{OFS_LNA_SEL, OFS_AMP_FIRST, OFS_AMP_SECOND,
                        OFS_GAIN_MARGIN, OFS_LOW_BETA};

  always #5 clk = ~clk;

  tsr_top u_tsr_top(.sys_clk_in(clk), .rst_n_in(rst_n), .req_in(req),
    .temp_sample_in(sample), .low_index_correction_enable_in(en),
    .rdata_out(rdata), .rvalid_out(rvalid), .temp_in_progress_out(busy),
    .tune_out(tune), .lna_high_sens_out(hs), .margin_mismatch_out(mm),
    .freq_offset_hz_out(fo));
  tsr_host u_tsr_host(.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata),
    .req_out(req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rchk(input logic [6:0] a);
    u_tsr_host.rd(a, d);
    chk(d, m.exists(a) ? 40'(m[a]) : 40'h0);
  endtask

  task automatic w(input logic [6:0] a, input logic [7:0] dv);
    u_tsr_host.wr(a, dv);
    if (a inside {rw})
      m[a] = dv;
  endtask

  task automatic tchk();
    chk(tune, {8'(m[OFS_LNA_SEL]), 8'(m[OFS_AMP_FIRST]),
      8'(m[OFS_AMP_SECOND]), 8'(m[OFS_GAIN_MARGIN]), 8'(m[OFS_LOW_BETA])});
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    // Host holds off its first access after release
    repeat (4) @(negedge clk);
    m[OFS_TEMP_CTRL] = 8'h01;
    m[OFS_TEMP_RESULT] = RST_TEMP_RESULT;
    m[OFS_LNA_SEL] = RST_LNA_SEL;
    m[OFS_AMP_FIRST] = RST_AMP_FIRST;
    m[OFS_AMP_SECOND] = RST_AMP_SECOND;
    m[OFS_GAIN_MARGIN] = RST_GAIN_MARGIN;
    m[OFS_LOW_BETA] = RST_LOW_BETA;
    tchk();
    foreach (m[a]) rchk(7'(a));
    $display("Test reset values done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; en = 0; sample = 8'h00;
    err_total = 0; n_checks = 0;
    void'($urandom(58));
    do_reset();
    foreach (rw[i]) w(rw[i], 8'($urandom));
    w(OFS_TEMP_RESULT, 8'($urandom));
    w(7'h50, 8'($urandom));
    rchk(7'h50);
    foreach (m[a]) rchk(7'(a));
    tchk();
    $display("Test register access done");
    for (k = 0; k < 2; k++) begin
      // Boost values are host choices, left applied after the second pass
      w(OFS_AMP_FIRST, k ? 8'h5d : 8'h55);
      w(OFS_AMP_SECOND, k ? 8'h7c : 8'h70);
      w(OFS_LNA_SEL, k ? LNA_HIGH : RST_LNA_SEL);
      repeat (2) @(negedge clk);
      chk(hs, 40'(k));
      tchk();
    end
    for (k = 0; k < 6; k++) begin
      en = k[0];
      v = (k < 2) ? MARGIN_NORMAL : (k < 4) ? MARGIN_CORR_ON : 8'h30;
      w(OFS_GAIN_MARGIN, v);
      w(OFS_LOW_BETA, 8'($urandom));
      repeat (2) @(negedge clk);
      chk(mm, !(v == 0 || v == (en ? 8'h20 : 8'h30)));
      ex = en ? int'($signed(8'(m[OFS_LOW_BETA]))) * OFFSET_STEP_HZ : 0;
      chk(fo, 18'(ex));
    end
    $display("Test tuning outputs done");
    // Receiver stays idle here: no traffic besides the trigger, written again mid-conversion on the second pass
    for (k = 0; k < 2; k++) begin
      sample = 8'($urandom);
      w(OFS_TEMP_CTRL, 8'h08);
      chk(busy, 1);
      if (k == 1) w(OFS_TEMP_CTRL, 8'h08);
      c = 0;
      while (busy === 1'b1 && c < 40) begin
        @(negedge clk);
        c++;
      end
      if (c >= 40) begin
        err_total++;
        complete_run();
      end
      chk(c + 2 * k, CONV_CYCLES + 1);
      m[OFS_TEMP_RESULT] = sample;
      rchk(OFS_TEMP_RESULT);
      rchk(OFS_TEMP_CTRL);
    end
    $display("Test conversion done");
    do_reset();
    complete_run();
  end
endmodule

// *** tsr_host.sv ***
/*
 Host model for the register port of the temperature sense block.
 Assumes requests are taken on the rising edge and a read answers
 with rvalid within a few cycles.
*/
`timescale 1ns/10ps
module tsr_host
  import tsr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output tsr_req_s req_out
);
  initial req_out = '0;

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{1'b1, 1'b0, a, d};
    @(negedge clk_in);
    // Idle bus shows no stale value
    req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    int n;
    d = 'x;
    @(negedge clk_in);
    req_out = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_in);
    req_out = '{1'b0, 1'b0, ~a, 8'hff};
    for (n = 0; n < 4; n++) begin
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        break;
      end
      @(negedge clk_in);
    end
  endtask
endmodule

// *** tsr_pkg.sv ***
/*
 Package for the temperature sense, test register and reset block:
 register offsets, reset values, field positions, timing counts and the
 carrier structs. Assumes an 8-bit register port with 7-bit addresses,
 driven synchronously to a 100 MHz system clock.
*/
// What this block and its host do
// [RULE1] Writing one to the trigger bit starts a conversion; trigger reads zero.
// [RULE2] In-progress bit reads one during conversion, zero once it completes.
// [RULE3] Host keeps the receiver idle while a conversion runs.
// [RULE4] Temperature is an eight-bit read-only value, minus one degree per count.
// [RULE5] Sensitivity register: 0x1b normal (reset), 0x2d high sensitivity.
// [RULE6] Host sets first amp tuning to 0x5d for boost, 0x55 otherwise.
// [RULE7] Host sets second amp tuning to 0x7c for boost, 0x70 otherwise.
// [RULE8] Fading margin: 0x00 normal, 0x20 with correction on, 0x30 off.
// [RULE9] With correction on, offset equals signed register times 488 Hz.
// [RULE10] Power-on reset happens at supply; manual reset pin also accepted.
// [RULE11] Host waits at least 10 ms after power-on reset before access; the bench waits 4 clock cycles (40 ns).
// [RULE12] Host leaves the reset pin undriven during power-on reset; the bench drives rst_n low from time zero.
// [RULE13] Manual reset: pin high about 100 us, then host waits 5 ms; the bench holds rst_n low 16 cycles, then waits 4.
// [RULE14] Host may treat clock output activity as ready indication.
// [RULE15] Host polls in-progress bit until zero before reading temperature.
package tsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_TEMP_CTRL = 7'h4e;
  localparam logic [6:0] OFS_TEMP_RESULT = 7'h4f;
  localparam logic [6:0] OFS_LNA_SEL = 7'h58;
  localparam logic [6:0] OFS_AMP_FIRST = 7'h5a;
  localparam logic [6:0] OFS_AMP_SECOND = 7'h5c;
  localparam logic [6:0] OFS_GAIN_MARGIN = 7'h6f;
  localparam logic [6:0] OFS_LOW_BETA = 7'h71;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LNA_SEL = 8'h1b;
  localparam logic [7:0] LNA_HIGH = 8'h2d;
  localparam logic [7:0] RST_AMP_FIRST = 8'h55;
  localparam logic [7:0] RST_AMP_SECOND = 8'h70;
  localparam logic [7:0] RST_GAIN_MARGIN = 8'h30;
  localparam logic [7:0] MARGIN_NORMAL = 8'h00;
  localparam logic [7:0] MARGIN_CORR_ON = 8'h20;
  localparam logic [7:0] RST_LOW_BETA = 8'h00;
  localparam logic [7:0] RST_TEMP_RESULT = 8'h00;

  // Temperature control layout: bits 7-4 read 0, bits 1-0 read 01
  localparam int TRIG_BIT = 3;
  localparam int BUSY_BIT = 2;
  localparam logic [1:0] CTRL_LOW_FIXED = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 100;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int OFFSET_STEP_HZ = 488;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } tsr_req_s;

  typedef struct packed {
    logic [7:0] lna_gain_select;
    logic [7:0] amp_tune_first;
    logic [7:0] amp_tune_second;
    logic [7:0] fading_margin_select;
    logic [7:0] low_index_offset;
  } tsr_tune_s;

  typedef enum logic [1:0] {
    TSR_IDLE = 2'b00,
    TSR_CONV = 2'b01,
    TSR_DONE = 2'b11
  } tsr_state_e;

endpackage

// *** tsr_top.sv ***
/*
 Temperature sense control and result registers, test/tuning registers
 and reset release. Assumes a synchronous register port from the serial
 front end and an analog sensor sample presented on temp_sample_in.
*/
`timescale 1ns/10ps
module tsr_top
  import tsr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire tsr_req_s req_in,
  input wire logic [7:0] temp_sample_in,
  input wire logic low_index_correction_enable_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic temp_in_progress_out,
  output tsr_tune_s tune_out,
  output logic lna_high_sens_out,
  output logic margin_mismatch_out,
  output logic signed [17:0] freq_offset_hz_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  // Power-on and pin reset both arrive on rst_n_in  [RULE10]
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // ----------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

  tsr_state_e state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [7:0] temp_reading_r, temp_reading_nxt;
  logic trig;

  function automatic logic hit(input tsr_req_s r, input logic [6:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  assign trig = hit(req_in, OFS_TEMP_CTRL) && req_in.wdata[TRIG_BIT];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    temp_reading_nxt = temp_reading_r;
    case (state_r)
      TSR_IDLE: begin
        if (trig) begin  // [RULE1]
          state_nxt = TSR_CONV;
          cnt_nxt = '0;
        end
      end
      TSR_CONV: begin
        if (cnt_r == CONV_LAST) begin
          state_nxt = TSR_DONE;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      TSR_DONE: begin
        // Sensor counts down one step per degree  [RULE4]
        temp_reading_nxt = temp_sample_in;
        state_nxt = TSR_IDLE;
      end
      default: state_nxt = TSR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TSR_IDLE;
      cnt_r <= '0;
      temp_reading_r <= RST_TEMP_RESULT;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      temp_reading_r <= temp_reading_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Tuning registers
  // ----------------------------------------------------------------
  tsr_tune_s tune_r, tune_nxt;

  always_comb begin
    tune_nxt = tune_r;
    if (hit(req_in, OFS_LNA_SEL)) begin  // [RULE5]
      tune_nxt.lna_gain_select = req_in.wdata;
    end
    if (hit(req_in, OFS_AMP_FIRST)) begin
      tune_nxt.amp_tune_first = req_in.wdata;
    end
    if (hit(req_in, OFS_AMP_SECOND)) begin
      tune_nxt.amp_tune_second = req_in.wdata;
    end
    if (hit(req_in, OFS_GAIN_MARGIN)) begin  // [RULE8]
      tune_nxt.fading_margin_select = req_in.wdata;
    end
    if (hit(req_in, OFS_LOW_BETA)) begin  // [RULE9]
      tune_nxt.low_index_offset = req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tune_r.lna_gain_select <= RST_LNA_SEL;  // [RULE5]
      tune_r.amp_tune_first <= RST_AMP_FIRST;
      tune_r.amp_tune_second <= RST_AMP_SECOND;
      tune_r.fading_margin_select <= RST_GAIN_MARGIN;  // [RULE8]
      tune_r.low_index_offset <= RST_LOW_BETA;  // [RULE9]
    end else begin
      tune_r <= tune_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port and registered outputs
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic busy_nxt;
  logic lna_high_nxt;
  logic mismatch_nxt;
  logic signed [17:0] offset_nxt;
  logic [7:0] ctrl_view;

  // Trigger field never stored, so it always reads zero  [RULE1]
  assign ctrl_view = {4'h0, 1'b0, (state_nxt != TSR_IDLE),
                      CTRL_LOW_FIXED};

  always_comb begin
    rdata_nxt = 8'h00;
    case (req_in.addr)
      OFS_TEMP_CTRL: rdata_nxt = ctrl_view;  // [RULE2]
      OFS_TEMP_RESULT: rdata_nxt = temp_reading_r;  // [RULE4]
      OFS_LNA_SEL: rdata_nxt = tune_r.lna_gain_select;
      OFS_AMP_FIRST: rdata_nxt = tune_r.amp_tune_first;
      OFS_AMP_SECOND: rdata_nxt = tune_r.amp_tune_second;
      OFS_GAIN_MARGIN: rdata_nxt = tune_r.fading_margin_select;
      OFS_LOW_BETA: rdata_nxt = tune_r.low_index_offset;
      default: rdata_nxt = 8'h00;
    endcase
    busy_nxt = (state_nxt != TSR_IDLE);  // [RULE2]
    lna_high_nxt = (tune_nxt.lna_gain_select == LNA_HIGH);  // [RULE5]
    // Flags a margin setting that does not suit the correction mode
    mismatch_nxt = (tune_nxt.fading_margin_select != MARGIN_NORMAL) &&
      (tune_nxt.fading_margin_select != (low_index_correction_enable_in ?
        MARGIN_CORR_ON : RST_GAIN_MARGIN));  // [RULE8]
    // Signed byte scaled by the step; zero while correction is off
    offset_nxt = low_index_correction_enable_in ?
      18'(signed'(tune_nxt.low_index_offset) * 18'sd488) :
      18'sd0;  // [RULE9]
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
      temp_in_progress_out <= 1'b0;
      tune_out <= '0;
      lna_high_sens_out <= 1'b0;
      margin_mismatch_out <= 1'b0;
      freq_offset_hz_out <= 18'sd0;
    end else begin
      rdata_out <= rdata_nxt;
      rvalid_out <= req_in.rd;
      temp_in_progress_out <= busy_nxt;
      tune_out <= tune_nxt;
      lna_high_sens_out <= lna_high_nxt;
      margin_mismatch_out <= mismatch_nxt;
      freq_offset_hz_out <= offset_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TRIG_STARTS: assert property (  // [RULE1]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (state_r == TSR_IDLE && trig) |=> temp_in_progress_out)
    else $error("Trigger did not start conversion");

  AST_TRIG_READS_ZERO: assert property (  // [RULE1]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (req_in.rd && req_in.addr == OFS_TEMP_CTRL) |=> !rdata_out[TRIG_BIT])
    else $error("Trigger bit read back as one");

  AST_BUSY_ENDS: assert property (  // [RULE2]
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(temp_in_progress_out) |-> ##[1:20] !temp_in_progress_out)
    else $error("Conversion never completed");

  // Busy lasts the count plus the capture cycle, no more, no less
  AST_BUSY_LENGTH: assert property (  // [RULE2]
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(temp_in_progress_out) |->
      ##10 temp_in_progress_out ##1 !temp_in_progress_out)
    else $error("Conversion length wrong");

  AST_BUSY_READBACK: assert property (  // [RULE2]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (req_in.rd && req_in.addr == OFS_TEMP_CTRL) |=>
      rdata_out[BUSY_BIT] == temp_in_progress_out)
    else $error("Busy bit disagrees with status output");

  AST_CTRL_FIXED: assert property (  // [RULE2]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (req_in.rd && req_in.addr == OFS_TEMP_CTRL) |=>
      (rdata_out[7:4] == 4'h0 && rdata_out[1:0] == CTRL_LOW_FIXED))
    else $error("Fixed control bits wrong");

  // Counter never runs past its last value
  AST_CNT_BOUND: assert property (  // [RULE2]
    @(posedge sys_clk_in) disable iff (!rst_n)
    cnt_r <= CONV_LAST)
    else $error("Conversion counter out of range");

  AST_RESULT_STABLE: assert property (  // [RULE4]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (state_r != TSR_DONE) |=> $stable(temp_reading_r))
    else $error("Result changed outside completion");

  AST_RESULT_LOAD: assert property (  // [RULE4]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (state_r == TSR_DONE) |=> temp_reading_r == $past(temp_sample_in))
    else $error("Result not taken from sensor");

  AST_LNA_FLAG: assert property (  // [RULE5]
    @(posedge sys_clk_in) disable iff (!rst_n)
    lna_high_sens_out == (tune_out.lna_gain_select == LNA_HIGH))
    else $error("Sensitivity flag mismatch");

  AST_LNA_WRITE: assert property (  // [RULE5]
    @(posedge sys_clk_in) disable iff (!rst_n)
    hit(req_in, OFS_LNA_SEL) |=>
      tune_out.lna_gain_select == $past(req_in.wdata))
    else $error("Sensitivity write lost");

  AST_MARGIN_RESET: assert property (  // [RULE8]
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(rst_n) |-> tune_r.fading_margin_select == RST_GAIN_MARGIN)
    else $error("Margin reset value wrong");

  // Normal margin suits either correction mode
  AST_MARGIN_NORMAL_OK: assert property (  // [RULE8]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (tune_out.fading_margin_select == MARGIN_NORMAL) |-> !margin_mismatch_out)
    else $error("Normal margin flagged");

  AST_OFFSET_OFF: assert property (  // [RULE9]
    @(posedge sys_clk_in) disable iff (!rst_n)
    !low_index_correction_enable_in |=> freq_offset_hz_out == 18'sd0 ||
      low_index_correction_enable_in)
    else $error("Offset applied with correction off");

  AST_OFFSET_SCALE: assert property (  // [RULE9]
    @(posedge sys_clk_in) disable iff (!rst_n)
    (low_index_correction_enable_in && $stable(tune_r)) |=>
      freq_offset_hz_out == 18'(signed'(tune_out.low_index_offset) * 18'sd488))
    else $error("Offset scaling wrong");

  AST_READ_ANSWER: assert property (  // [RULE4]
    @(posedge sys_clk_in) disable iff (!rst_n)
    req_in.rd |=> rvalid_out)
    else $error("Read not answered");

  // Stays active during reset so a stuck status flop is caught
  AST_RESET_SYNC: assert property (  // [RULE10]
    @(posedge sys_clk_in)
    !rst_n |-> !temp_in_progress_out)
    else $error("Busy set while in reset");

endmodule
